/* rtl/apcc_regs.svh */
// constants for the parallel conversion control block
`ifndef APCC_REGS_SVH
`define APCC_REGS_SVH
// ------------------------------------------------
// control byte field positions
// ------------------------------------------------
`define APCC_PD_HI_BIT      7
`define APCC_PD_LO_BIT      6
`define APCC_ACQ_BIT        5
`define APCC_INTYPE_BIT     4
`define APCC_POL_BIT        3
`define APCC_CHAN_MSB       2
`define APCC_CHAN_LSB       0
// ------------------------------------------------
// power field codes and reset values
// ------------------------------------------------
`define APCC_PD_SHUTDOWN    2'h0
`define APCC_PD_STANDBY     2'h1
`define APCC_PD_INT_CLK     2'h2
`define APCC_PD_EXT_CLK     2'h3
`define APCC_CTRL_RESET     8'hc0
// ------------------------------------------------
// timing
// ------------------------------------------------
`define APCC_CONV_CYCLES    13
`define APCC_ACQ_EXT_CYCLES 3
`define APCC_ACQ_INT_NS     1000
`define APCC_POR_US         10
`define APCC_CLK_NS         20
`define APCC_INT_CONV_NS    3600
`endif

/* rtl/apcc_pkg.sv */
// types for the parallel conversion control block
package apcc_pkg;
    typedef enum logic [2:0] {
        APCC_POR,
        APCC_IDLE,
        APCC_ACQ_INT,
        APCC_ACQ_EXT,
        APCC_CONV
    } apcc_state_t;

    typedef struct packed {
        logic [1:0] power_state;
        logic       acquisition_timing_select;
        logic       input_type_select;
        logic       polarity_select;
        logic [2:0] channel_sel;
    } apcc_ctrl_t;

    typedef struct packed {
        logic [11:0] result;
        logic        valid;
    } apcc_sample_t;
endpackage

/* rtl/apcc_top.sv */
// conversion control for a parallel-bus successive-approximation converter
`timescale 1ns/1ps
`include "apcc_regs.svh"
module apcc_top #(
    parameter int POR_CYCLES  = (`APCC_POR_US * 1000 + `APCC_CLK_NS - 1) / `APCC_CLK_NS,
    parameter int INT_DIV     = (`APCC_INT_CONV_NS / `APCC_CONV_CYCLES) / `APCC_CLK_NS,
    parameter int RESULT_BITS = 12
) (
    // clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RST,
    input  wire logic                   CE,
    // parallel bus pins, asynchronous
    input  wire logic                   CS_N,
    input  wire logic                   WR_N,
    input  wire logic                   RD_N,
    input  wire logic                   CONV_CLK,
    input  wire logic [7:0]             DATA_IN,
    // sampled converter core
    input  wire logic [RESULT_BITS-1:0] SAMPLE_CODE,
    // outputs
    output logic [RESULT_BITS-1:0]      DATA_OUT,
    output logic [RESULT_BITS-1:0]      DATA_OE_N,
    output logic                        INT_N,
    output logic                        TRACK,
    output logic                        POWERED,
    output apcc_pkg::apcc_ctrl_t        CTRL
);
    import apcc_pkg::*;

    // ------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [7:0] data1;
    logic [7:0] data2;
    always_ff @(posedge CLK) begin
        if (RST) begin
            sync1 <= 4'hf;
            sync2 <= 4'hf;
            sync3 <= 4'hf;
            data1 <= 8'h00;
            data2 <= 8'h00;
        end else if (CE) begin
            sync1 <= {CS_N, WR_N, RD_N, ~CONV_CLK};
            sync2 <= sync1;
            sync3 <= sync2;
            data1 <= DATA_IN;
            data2 <= data1;
        end
    end

    // chip select high masks every strobe and the clock
    logic cs_act;
    logic wr_rise;
    logic rd_fall;
    logic rd_act;
    logic cclk_fall;
    assign cs_act    = ~sync2[3];
    assign wr_rise   = cs_act & sync2[2] & ~sync3[2];
    assign rd_act    = cs_act & ~sync2[1];
    assign rd_fall   = rd_act & sync3[1];
    assign cclk_fall = cs_act & sync2[0] & ~sync3[0];

    // ------------------------------------------------
    // control byte and clock source
    // ------------------------------------------------
    apcc_ctrl_t  next_ctrl;
    logic        ext_clk;
    logic        powered_down;
    apcc_state_t state;
    assign next_ctrl = apcc_ctrl_t'(data2);

    always_ff @(posedge CLK) begin
        if (RST) begin
            CTRL    <= apcc_ctrl_t'(`APCC_CTRL_RESET);
            ext_clk <= 1'b1;
        end else if (CE && wr_rise && state != APCC_POR) begin
            CTRL <= next_ctrl;
            case (next_ctrl.power_state)
                `APCC_PD_INT_CLK: ext_clk <= 1'b0;
                `APCC_PD_EXT_CLK: ext_clk <= 1'b1;
                default:          ext_clk <= ext_clk;
            endcase
        end
    end
    assign powered_down = ~next_ctrl.power_state[1];

    // ------------------------------------------------
    // conversion clock tick: pin edge or internal divider
    // ------------------------------------------------
    logic [15:0] div_cnt;
    logic        int_tick;
    logic        tick;
    always_ff @(posedge CLK) begin
        if (RST) begin
            div_cnt <= 16'h0000;
        end else if (CE) begin
            if (wr_rise || int_tick) begin
                div_cnt <= 16'h0000;
            end else begin
                div_cnt <= div_cnt + 16'h0001;
            end
        end
    end
    assign int_tick = (div_cnt == 16'(INT_DIV - 1));
    assign tick     = ext_clk ? cclk_fall : int_tick;

    // ------------------------------------------------
    // sequencer
    // ------------------------------------------------
    logic [15:0] cnt;
    logic        shut_pending;
    logic        done;
    always_ff @(posedge CLK) begin
        if (RST) begin
            state        <= APCC_POR;
            cnt          <= 16'h0000;
            shut_pending <= 1'b0;
            done         <= 1'b0;
        end else if (CE) begin
            done <= 1'b0;
            case (state)
                APCC_POR: begin
                    // writes during the internal reset are dropped
                    cnt <= cnt + 16'h0001;
                    if (cnt == 16'(POR_CYCLES - 1)) begin
                        state <= APCC_IDLE;
                        cnt   <= 16'h0000;
                    end
                end
                default: begin
                    if (wr_rise) begin
                        cnt <= 16'h0000;
                        // a fresh write aborts any conversion
                        if (state == APCC_ACQ_EXT && !next_ctrl.acquisition_timing_select) begin
                            state <= APCC_CONV;
                        end else if (powered_down) begin
                            state <= APCC_IDLE;
                        end else if (next_ctrl.acquisition_timing_select) begin
                            state <= APCC_ACQ_EXT;
                        end else begin
                            state <= APCC_ACQ_INT;
                        end
                        shut_pending <= (next_ctrl.power_state == `APCC_PD_SHUTDOWN);
                    end else if (tick) begin
                        case (state)
                            APCC_ACQ_INT: begin
                                cnt <= cnt + 16'h0001;
                                if (cnt == 16'(`APCC_ACQ_EXT_CYCLES)) begin
                                    state <= APCC_CONV;
                                    cnt   <= 16'h0000;
                                end
                            end
                            APCC_CONV: begin
                                cnt <= cnt + 16'h0001;
                                if (cnt == 16'(`APCC_CONV_CYCLES - 1)) begin
                                    state <= APCC_IDLE;
                                    done  <= 1'b1;
                                end
                            end
                            default: state <= state;
                        endcase
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------
    // result, interrupt and bus drive
    // ------------------------------------------------
    logic [RESULT_BITS-1:0] result;
    always_ff @(posedge CLK) begin
        if (RST) begin
            result <= '0;
            INT_N  <= 1'b1;
        end else if (CE) begin
            if (done) begin
                // core code is straight binary; flip msb for bipolar
                result <= CTRL.polarity_select ? SAMPLE_CODE :
                          {~SAMPLE_CODE[RESULT_BITS-1], SAMPLE_CODE[RESULT_BITS-2:0]};
            end
            if (wr_rise || rd_fall) begin
                INT_N <= 1'b1;
            end else if (done) begin
                INT_N <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            DATA_OUT  <= '0;
            DATA_OE_N <= '1;
            TRACK     <= 1'b0;
            POWERED   <= 1'b1;
        end else if (CE) begin
            DATA_OUT  <= result;
            DATA_OE_N <= {RESULT_BITS{~rd_act}};
            TRACK     <= (state == APCC_ACQ_INT) || (state == APCC_ACQ_EXT);
            POWERED   <= !(shut_pending && state == APCC_IDLE) &&
                         !(CTRL.power_state == `APCC_PD_STANDBY && state == APCC_IDLE);
        end
    end
endmodule

/* verification/apcc_checker.sv */
// port assertions for the parallel conversion control block
`timescale 1ns/1ps
module apcc_checker #(
    parameter int RESULT_BITS = 12
) (
    // watched ports
    input wire logic                   CLK,
    input wire logic                   RST,
    input wire logic                   CS_N,
    input wire logic                   RD_N,
    input wire logic [RESULT_BITS-1:0] DATA_OUT,
    input wire logic [RESULT_BITS-1:0] DATA_OE_N,
    input wire logic                   INT_N,
    input wire logic                   TRACK,
    input wire logic                   POWERED,
    input wire apcc_pkg::apcc_ctrl_t   CTRL
);
    // pins pass a two-flop synchronizer, so answers trail the pins by a few cycles
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_bus_float: assert property (CS_N [*4] |-> &DATA_OE_N)
        else $error("data pins driven while deselected");
    a_read_drive: assert property ((!CS_N && !RD_N) [*4] |-> DATA_OE_N == '0)
        else $error("data pins not driven during read");
    a_int_read: assert property ((!CS_N && !RD_N) [*5] |-> INT_N)
        else $error("completion flag kept low through a read");
    a_int_ready: assert property ($changed(DATA_OUT) |-> ##[0:1] !INT_N)
        else $error("result changed without completion flag");
    a_result_hold: assert property (!INT_N [*3] |-> $stable(DATA_OUT))
        else $error("result moved while flagged ready");
    a_int_busy: assert property (TRACK && $past(TRACK) |-> INT_N)
        else $error("completion flag low during acquisition");
    a_track_power: assert property (TRACK && $past(TRACK) |-> POWERED)
        else $error("acquisition while powered down");
    a_reset_state: assert property ($fell(RST) |-> CTRL == 8'hc0 && INT_N)
        else $error("wrong state after reset");
endmodule
bind apcc_top apcc_checker #(.RESULT_BITS(RESULT_BITS)) i_checker (
    .CLK(CLK), .RST(RST), .CS_N(CS_N), .RD_N(RD_N), .DATA_OUT(DATA_OUT),
    .DATA_OE_N(DATA_OE_N), .INT_N(INT_N), .TRACK(TRACK), .POWERED(POWERED), .CTRL(CTRL));

/* verification/apcc_host.sv */
// bus master model standing in for the microprocessor
`timescale 1ns/1ps
module apcc_host (
    // clock
    input  wire logic  clk,
    // pins toward the converter
    output logic       cs_n     = 1'b1,
    output logic       wr_n     = 1'b1,
    output logic       rd_n     = 1'b1,
    output logic       conv_clk = 1'b0,
    output logic [7:0] data     = 8'h00
);
    // 4 MHz, inside the allowed band; left free-running for simplicity
    always #125 conv_clk = ~conv_clk;
    // one strobe cycle: a write, or a read when rd is set
    task automatic xfer(input logic [7:0] b, input logic cs, input logic rd);
        @(posedge clk);
        #2;
        cs_n = cs;
        data = b;
        wr_n = rd;
        rd_n = !rd;
        repeat (6) @(posedge clk);
        #2;
        wr_n = 1'b1;
        rd_n = 1'b1;
        // data outlives the strobe since the pins are sampled late
        repeat (3) @(posedge clk);
        #2;
        // stay selected: a deselected part ignores the conversion clock
        cs_n = cs;
        data = ~b;
    endtask
endmodule

/* verification/adc_parallel_conversion_control_test.sv */
// self-checking bench for the parallel conversion control block
`timescale 1ns/1ps
module adc_parallel_conversion_control_test;
    import apcc_pkg::*;
    logic        clk;
    logic        rst  = 1'b1;
    logic [11:0] code = 12'h000;
    logic [11:0] dout;
    logic [11:0] oe_n;
    logic        int_n;
    logic        track;
    logic        powered;
    apcc_ctrl_t  ctrl;
    wire         cs_n, wr_n, rd_n, conv_clk;
    wire [7:0]   data;
    int          error_cnt   = 0;
    int          checks_done = 0;
    int          seed        = 32'h336bd6d2;
    int          n;
    int          tl          = 0;
    int          tl_last     = 0;
    logic [11:0] exp_q[$];
    logic [7:0]  mode [4]    = '{8'hc8, 8'h80, 8'hd9, 8'h95};
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    apcc_top #(.POR_CYCLES(5)) i_dut (
        .CLK(clk), .RST(rst), .CE(1'b1), .CS_N(cs_n), .WR_N(wr_n), .RD_N(rd_n),
        .CONV_CLK(conv_clk), .DATA_IN(data), .SAMPLE_CODE(code), .DATA_OUT(dout),
        .DATA_OE_N(oe_n), .INT_N(int_n), .TRACK(track), .POWERED(powered), .CTRL(ctrl));
    apcc_host i_host (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .conv_clk(conv_clk), .data(data));
    task automatic chk(input string what, input logic [11:0] e, input logic [11:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chkr(input string what, input int lo, input int hi, input int x);
        chk(what, 12'((x >= lo && x <= hi) ? x : lo), 12'(x));
    endtask
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // results are compared whenever the bus turns round for a read
    always @(negedge oe_n[0]) begin
        #1;
        if (exp_q.size() == 0) chk("extra read", 12'h0, 12'h1);
        else chk("result", exp_q.pop_front(), dout);
    end
    always @(posedge clk) begin
        if (track === 1'b1) tl <= tl + 1;
        else if (tl != 0) begin
            tl_last <= tl;
            tl <= 0;
        end
    end
    task automatic conv(input logic [7:0] b, input logic [7:0] b2, input logic ab);
        @(posedge clk);
        #2 code = 12'($random(seed));
        exp_q.push_back(b[3] ? code : code ^ 12'h800);
        i_host.xfer(b, 1'b0, 1'b0);
        if (ab) begin
            repeat (100) step;
            chk("int_n aborted", 12'h1, 12'(int_n));
            i_host.xfer(b, 1'b0, 1'b0);
        end
        if (b[5]) begin
            repeat (40) step;
            chk("track held", 12'h1, 12'(track));
            i_host.xfer(b2, 1'b0, 1'b0);
        end
        if (!b[5]) for (n = 0; n < 2000 && track !== 1'b1; n++) step;
        if (n == 2000) begin
            chk("wait track high", 12'h0, 12'h1);
            report_and_stop;
        end
        for (n = 0; n < 2000 && track !== 1'b0; n++) step;
        if (n == 2000) begin
            chk("wait track low", 12'h0, 12'h1);
            report_and_stop;
        end
        for (n = 0; n < 2000 && int_n !== 1'b0; n++) step;
        if (n == 2000) begin
            chk("wait int_n", 12'h0, 12'h1);
            report_and_stop;
        end
        if (!b[5]) chkr("acq cycles", 36, 56, tl_last);
        if (!b[5]) chkr("conv cycles", b[6] ? 160 : 167, b[6] ? 168 : 173, n);
        i_host.xfer(8'h00, 1'b0, 1'b1);
        step;
        chk("int_n read", 12'h1, 12'(int_n));
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #2 rst = 1'b0;
        repeat (20) step;
        chk("int_n reset", 12'h1, 12'(int_n));
        chk("ctrl reset", 12'h0c0, 12'(ctrl));
        i_host.xfer(8'h55, 1'b1, 1'b0);
        i_host.xfer(8'h00, 1'b1, 1'b1);
        step;
        chk("ctrl deselected", 12'h0c0, 12'(ctrl));
        foreach (mode[i]) conv(mode[i], 8'h00, 1'b0);
        conv(8'he8, 8'h88, 1'b0);
        conv(8'hc8, 8'h00, 1'b1);
        for (int p = 0; p < 2; p++) begin
            i_host.xfer(p ? 8'h08 : 8'h48, 1'b0, 1'b0);
            repeat (300) step;
            chk("powered", 12'h0, 12'(powered));
            chk("int_n idle", 12'h1, 12'(int_n));
            conv(8'hc8, 8'h00, 1'b0);
        end
        report_and_stop;
    end
endmodule
